// ==== free_running_match_counter.sv ====
// Free-running 32-bit match counter with register port
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "frt_defs.svh"
module free_running_match_counter
  import frt_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DIV   = `FRT_OSC_DIV
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   nrst_i,
  input  wire logic                   ce_i,
  input  wire logic                   int_osc_i,
  input  wire logic                   ext_osc_i,
  input  wire logic                   sub_osc_i,
  input  wire logic [`FRT_ADDR_W-1:0] addr_i,
  input  wire logic [31:0]            wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [31:0]            rdata_o,
  output logic                        irq_o,
  output logic                        wakeup_o
);

  function automatic logic hit(input logic [`FRT_ADDR_W-1:0] a,
                               input logic [`FRT_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  mode_t            mode_r;
  ctrl_t            ctrl_r;
  logic [WIDTH-1:0] period_r;
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic [WIDTH-1:0] snap_r;
  logic             stall_r;
  logic             match_evt_r;
  logic             ovf_evt_r;
  rd_state_t        rd_st_r;
  rd_state_t        rd_st_nxt;
  logic             tick_int;
  logic             tick_ext;
  logic             tick_sub;
  logic             match_flag;
  logic             overflow_flag;
  logic             read_ready_flag;
  logic [31:0]      rdata_nxt;

  // Register decode
  wire wr_mode   = wr_i && hit(addr_i, `FRT_OFF_MODE);
  wire wr_ctrl   = wr_i && hit(addr_i, `FRT_OFF_CTRL);
  wire wr_period = wr_i && hit(addr_i, `FRT_OFF_PERIOD);
  wire wr_flags  = wr_i && hit(addr_i, `FRT_OFF_FLAGS);
  wire clr_cmd   = wr_ctrl && wdata_i[`FRT_CTRL_CLR];

  // Source ticks, each a sampled oscillator turned into a single pulse
  frt_tick_gen #(.DIV(DIV)) u_tick_int (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .src_i     (int_osc_i),
    .tick_o    (tick_int)
  );
  frt_tick_gen #(.DIV(DIV)) u_tick_ext (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .src_i     (ext_osc_i),
    .tick_o    (tick_ext)
  );
  frt_tick_gen #(.DIV(1)) u_tick_sub (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .src_i     (sub_osc_i),
    .tick_o    (tick_sub)
  );

  // Reserved select gives no ticks at all, so the counter just stops
  wire tick_sel = (mode_r.count_clock_select == SRC_INT_DIV) ? tick_int :
                  (mode_r.count_clock_select == SRC_EXT_DIV) ? tick_ext :
                  (mode_r.count_clock_select == SRC_SUB)     ? tick_sub :
                  1'b0;

  wire running = ctrl_r.unit_enable_bit && !ctrl_r.counter_hold &&
                 !stall_r && tick_sel;
  wire [WIDTH-1:0] cnt_inc = cnt_r + WIDTH'(1);
  wire match_clr = match_evt_r && !mode_r.match_clear_disable;

  always_comb begin
    cnt_nxt = cnt_r;
    if (clr_cmd) begin
      cnt_nxt = '0;
    end else if (match_clr) begin
      cnt_nxt = '0;
    end else if (running) begin
      cnt_nxt = cnt_inc;
    end
  end

  // Events are registered in the system domain before touching flags
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cnt_r       <= '0;
      match_evt_r <= 1'b0;
      ovf_evt_r   <= 1'b0;
      stall_r     <= 1'b0;
    end else if (ce_i) begin
      cnt_r       <= cnt_nxt;
      match_evt_r <= running && !clr_cmd && (cnt_inc == period_r);
      ovf_evt_r   <= running && !clr_cmd && (&cnt_inc);
      if (match_clr) begin
        stall_r <= 1'b1;
      end else if (!match_flag || clr_cmd) begin
        stall_r <= 1'b0;
      end
    end
  end

  // Software registers
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      mode_r   <= mode_t'(`FRT_RST_MODE);
      ctrl_r   <= '0;
      period_r <= WIDTH'(`FRT_RST_PERIOD);
    end else if (ce_i) begin
      if (wr_mode) begin
        mode_r <= mode_t'(wdata_i[`FRT_MODE_SEL_HI:0]);
      end
      if (wr_period) begin
        period_r <= wdata_i[WIDTH-1:0];
      end
      if (wr_ctrl) begin
        ctrl_r.unit_enable_bit <= wdata_i[`FRT_CTRL_EN];
        ctrl_r.counter_hold    <= wdata_i[`FRT_CTRL_HOLD];
      end
      if (wr_ctrl && wdata_i[`FRT_CTRL_REQ]) begin
        ctrl_r.count_read_request <= 1'b1;
      end else if (read_ready_flag) begin
        ctrl_r.count_read_request <= 1'b0;
      end else if (wr_ctrl) begin
        ctrl_r.count_read_request <= 1'b0;
      end
    end
  end

  // Read handshake: one snapshot per request, kept stable for software
  wire snap_take = (rd_st_r == RD_IDLE) && ctrl_r.count_read_request &&
                   !read_ready_flag;

  always_comb begin
    case (rd_st_r)
      RD_IDLE: rd_st_nxt = snap_take ? RD_DONE : RD_IDLE;
      RD_DONE: rd_st_nxt = read_ready_flag ? RD_DONE : RD_IDLE;
      default: rd_st_nxt = RD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rd_st_r <= RD_IDLE;
      snap_r  <= '0;
    end else if (ce_i) begin
      rd_st_r <= rd_st_nxt;
      if (snap_take) begin
        snap_r <= cnt_r;
      end
    end
  end

  frt_flag u_match_flag (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .set_i     (match_evt_r),
    .clr_i     (wr_flags && wdata_i[`FRT_FLAG_MATCH]),
    .flag_o    (match_flag)
  );
  frt_flag u_overflow_flag (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .set_i     (ovf_evt_r),
    .clr_i     (wr_flags && wdata_i[`FRT_FLAG_OVF]),
    .flag_o    (overflow_flag)
  );
  frt_flag u_read_ready_flag (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .set_i     (snap_take),
    .clr_i     (wr_flags && wdata_i[`FRT_FLAG_ACK]),
    .flag_o    (read_ready_flag)
  );

  // Read mux; the count register ignores writes entirely
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (addr_i)
      `FRT_OFF_MODE:   rdata_nxt[`FRT_MODE_SEL_HI:0] = mode_r;
      `FRT_OFF_CTRL:   rdata_nxt[`FRT_CTRL_REQ:0] =
                         {ctrl_r.count_read_request, 1'b0,
                          ctrl_r.counter_hold, ctrl_r.unit_enable_bit};
      `FRT_OFF_PERIOD: rdata_nxt[WIDTH-1:0] = period_r;
      `FRT_OFF_COUNT:  rdata_nxt[WIDTH-1:0] = snap_r;
      `FRT_OFF_FLAGS:  rdata_nxt[`FRT_FLAG_ACK:0] =
                         {read_ready_flag, overflow_flag, match_flag};
      default:         rdata_nxt = 32'h0000_0000;
    endcase
  end

  wire irq_nxt = (match_flag && mode_r.match_irq_enable) ||
                 (overflow_flag && mode_r.overflow_irq_enable);

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rdata_o  <= 32'h0000_0000;
      irq_o    <= 1'b0;
      wakeup_o <= 1'b0;
    end else if (ce_i) begin
      rdata_o  <= rd_i ? rdata_nxt : 32'h0000_0000;
      irq_o    <= irq_nxt;
      wakeup_o <= irq_nxt;
    end
  end

  AST_MATCH_CLEARS: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && match_evt_r && !mode_r.match_clear_disable |=> cnt_r == '0)
    else $error("count not zeroed after match");

  // The stall is what lets software see the match before counting resumes
  AST_STALL_HOLDS: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && stall_r && !clr_cmd && !match_clr |=> $stable(cnt_r))
    else $error("count moved while waiting for match flag clear");

  AST_MATCH_KEEPS_COUNT: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && match_evt_r && mode_r.match_clear_disable && !clr_cmd &&
    !running |=> cnt_r == $past(cnt_r))
    else $error("count changed through match with clear disabled");

  AST_IRQ_LATENCY: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && match_evt_r && mode_r.match_irq_enable && !wr_flags &&
    !wr_mode ##1 ce_i |=> irq_o)
    else $error("interrupt late after match");

  AST_WAKE_LATENCY: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && match_evt_r && mode_r.match_irq_enable && !wr_flags &&
    !wr_mode ##1 ce_i |=> wakeup_o)
    else $error("wakeup late after match");

  AST_IRQ_MASKED: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && !mode_r.match_irq_enable && !mode_r.overflow_irq_enable
    |=> !irq_o)
    else $error("interrupt raised while masked");

  AST_REQ_SELF_CLEAR: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && read_ready_flag && !wr_ctrl |=> !ctrl_r.count_read_request)
    else $error("read request not cleared after ack");

  AST_ACK_SNAPSHOT: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && snap_take |=> read_ready_flag && snap_r == $past(cnt_r))
    else $error("ack without matching snapshot");

  AST_CLEAR_CMD: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && clr_cmd |=> cnt_r == '0)
    else $error("clear command ignored");

  AST_HOLD_FREEZE: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && (ctrl_r.counter_hold || !ctrl_r.unit_enable_bit) && !clr_cmd &&
    !match_clr |=> $stable(cnt_r))
    else $error("count moved while held or disabled");

  AST_STEP_ONE: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && running && !clr_cmd && !match_clr |=> cnt_r == $past(cnt_inc))
    else $error("count did not step by one");

  AST_OVF_FLAG: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && ovf_evt_r |=> overflow_flag)
    else $error("overflow flag not set");

endmodule : free_running_match_counter

// ==== frt_defs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef FRT_DEFS_SVH
`define FRT_DEFS_SVH

`define FRT_ADDR_W        8
`define FRT_OFF_MODE      8'h00
`define FRT_OFF_CTRL      8'h04
`define FRT_OFF_PERIOD    8'h08
`define FRT_OFF_COUNT     8'h0c
`define FRT_OFF_FLAGS     8'h10

`define FRT_MODE_MATCH_IRQ 0
`define FRT_MODE_OVF_IRQ  1
`define FRT_MODE_KEEP     2
`define FRT_MODE_SEL_LO   3
`define FRT_MODE_SEL_HI   4

`define FRT_CTRL_EN       0
`define FRT_CTRL_HOLD     1
`define FRT_CTRL_CLR      2
`define FRT_CTRL_REQ      3

`define FRT_FLAG_MATCH    0
`define FRT_FLAG_OVF      1
`define FRT_FLAG_ACK      2

`define FRT_RST_MODE      5'h00
`define FRT_RST_PERIOD    32'h0000_0000
`define FRT_OSC_DIV       16

`endif

// ==== frt_pkg.sv ====
// Types shared by the free-running match counter
package frt_pkg;

  typedef enum logic [1:0] {
    SRC_INT_DIV = 2'h0,
    SRC_EXT_DIV = 2'h1,
    SRC_SUB     = 2'h2,
    SRC_RSVD    = 2'h3
  } clk_src_t;

  typedef struct packed {
    clk_src_t count_clock_select;
    logic     match_clear_disable;
    logic     overflow_irq_enable;
    logic     match_irq_enable;
  } mode_t;

  typedef struct packed {
    logic count_read_request;
    logic counter_hold;
    logic unit_enable_bit;
  } ctrl_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DONE = 2'b10
  } rd_state_t;

endpackage : frt_pkg

// ==== frt_tick_gen.sv ====
// Edge detector and divider turning a sampled oscillator into count ticks
`timescale 1ns/1ps
module frt_tick_gen #(
  parameter int DIV = 16
) (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic src_i,
  output logic      tick_o
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic          src_d_r;
  logic [CW-1:0] div_r;
  wire           rise_w = src_i & ~src_d_r;
  wire           last_w = (DIV <= 1) || (div_r == CW'(DIV - 1));

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      src_d_r <= 1'b0;
      div_r   <= '0;
      tick_o  <= 1'b0;
    end else if (ce_i) begin
      src_d_r <= src_i;
      tick_o  <= rise_w & last_w;
      if (rise_w) begin
        div_r <= last_w ? '0 : div_r + CW'(1);
      end
    end
  end
endmodule : frt_tick_gen

// ==== frt_flag.sv ====
// Sticky status bit: hardware set wins over a software clear
`timescale 1ns/1ps
module frt_flag (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      flag_o <= 1'b0;
    end else if (ce_i) begin
      if (set_i) begin
        flag_o <= 1'b1;
      end else if (clr_i) begin
        flag_o <= 1'b0;
      end
    end
  end
endmodule : frt_flag

// ==== tb.sv ====
// Register-level testbench for the free-running match counter
`timescale 1ns/1ps
`include "frt_defs.svh"
module tb;
  import frt_pkg::*;
  logic                   clk_sys_i;
  logic                   nrst_i;
  logic                   ce_i;
  logic                   int_osc_i;
  logic                   ext_osc_i;
  logic                   sub_osc_i;
  logic [`FRT_ADDR_W-1:0] addr_i;
  logic [31:0]            wdata_i;
  logic                   wr_i;
  logic                   rd_i;
  logic [31:0]            rdata_o;
  logic                   irq_o;
  logic                   wakeup_o;
  logic [31:0]            rdata_s;
  logic                   irq_s;
  logic [31:0]            rd_val;
  logic [31:0]            rd_sml;
  logic [31:0]            ctl;
  int                     num_errors;
  int                     tests_run;

  free_running_match_counter #(.WIDTH(32), .DIV(2)) i_dut (
    .clk_sys_i, .nrst_i, .ce_i, .int_osc_i, .ext_osc_i, .sub_osc_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o, .wakeup_o);

  // Narrow copy on the same stimulus: overflow is out of reach at 32 bits
  free_running_match_counter #(.WIDTH(8), .DIV(2)) i_small (
    .clk_sys_i, .nrst_i, .ce_i, .int_osc_i, .ext_osc_i, .sub_osc_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o(rdata_s), .irq_o(irq_s),
    .wakeup_o());

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1;
    rd_val = rdata_o;
    rd_sml = rdata_s;
  endtask : rd

  // Bit 2 internal, bit 1 external, bit 0 sub; rises stay under half rate
  task automatic pulse(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      {int_osc_i, ext_osc_i, sub_osc_i} <= m;
      @(posedge clk_sys_i);
      {int_osc_i, ext_osc_i, sub_osc_i} <= 3'h0;
      @(posedge clk_sys_i);
    end
    repeat (6) @(posedge clk_sys_i);
  endtask : pulse

  task automatic snap(input logic [31:0] exp);
    int i;
    wr(`FRT_OFF_CTRL, ctl | 32'h8);
    for (i = 0; i < 8; i++) begin
      rd(`FRT_OFF_FLAGS);
      if (rd_val[`FRT_FLAG_ACK] === 1'b1) break;
    end
    chk("read ack", rd_val & 32'h4, 32'h4);
    if (i == 8) stop_test();
    rd(`FRT_OFF_CTRL);
    chk("request self clear", rd_val, ctl);
    rd(`FRT_OFF_COUNT);
    chk("count", rd_val, exp);
    wr(`FRT_OFF_FLAGS, 32'h4);
  endtask : snap

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    stop_test();
  end

  initial begin
    logic [7:0] offs [5];
    int         sel_exp [4];
    offs = '{`FRT_OFF_MODE, `FRT_OFF_CTRL, `FRT_OFF_PERIOD, `FRT_OFF_FLAGS,
             8'h14};
    // Distinct tick counts per source so a wrong select cannot hide
    sel_exp = '{2, 1, 4, 0};
    nrst_i = 1'b0;
    ce_i = 1'b1;
    {int_osc_i, ext_osc_i, sub_osc_i} = 3'h0;
    addr_i = '0;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    ctl = 32'h0;
    num_errors = 0;
    tests_run = 0;
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    foreach (offs[k]) begin
      rd(offs[k]);
      chk("reset or unmapped", rd_val, 32'h0);
    end
    chk("irq at reset", irq_o, 1'b0);
    $display("Test reset finished");

    wr(`FRT_OFF_PERIOD, 32'ha5a5_5a5a);
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    wr(`FRT_OFF_PERIOD, 32'h0);
    ce_i <= 1'b1;
    rd(`FRT_OFF_PERIOD);
    chk("period", rd_val, 32'ha5a5_5a5a);
    wr(`FRT_OFF_COUNT, 32'h55);
    snap(32'h0);
    $display("Test registers finished");

    wr(`FRT_OFF_MODE, 32'h10);
    pulse(3'h1, 3);
    snap(32'h0);
    ctl = 32'h1;
    wr(`FRT_OFF_CTRL, ctl);
    pulse(3'h1, 3);
    snap(32'h3);
    ctl = 32'h3;
    wr(`FRT_OFF_CTRL, ctl);
    pulse(3'h1, 2);
    snap(32'h3);
    ctl = 32'h1;
    wr(`FRT_OFF_CTRL, ctl);
    pulse(3'h1, 1);
    snap(32'h4);
    wr(`FRT_OFF_CTRL, 32'h5);
    snap(32'h0);
    $display("Test enable hold clear finished");

    for (int s = 0; s < 4; s++) begin
      wr(`FRT_OFF_MODE, 32'(s) << 3);
      wr(`FRT_OFF_CTRL, 32'h5);
      pulse(3'h4, 4);
      pulse(3'h2, 2);
      pulse(3'h1, 4);
      snap(32'(sel_exp[s]));
    end
    $display("Test clock select finished");

    wr(`FRT_OFF_PERIOD, 32'h3);
    wr(`FRT_OFF_MODE, 32'h11);
    wr(`FRT_OFF_CTRL, 32'h5);
    pulse(3'h1, 3);
    chk("match irq", irq_o, 1'b1);
    chk("match wakeup", wakeup_o, 1'b1);
    pulse(3'h1, 2);
    snap(32'h0);
    rd(`FRT_OFF_FLAGS);
    chk("match flag", rd_val, 32'h1);
    wr(`FRT_OFF_MODE, 32'h10);
    repeat (3) @(posedge clk_sys_i);
    chk("masked irq", irq_o, 1'b0);
    wr(`FRT_OFF_MODE, 32'h11);
    wr(`FRT_OFF_FLAGS, 32'h1);
    repeat (3) @(posedge clk_sys_i);
    chk("irq after clear", irq_o, 1'b0);
    pulse(3'h1, 2);
    snap(32'h2);
    $display("Test match clear finished");

    wr(`FRT_OFF_MODE, 32'h14);
    wr(`FRT_OFF_CTRL, 32'h5);
    wr(`FRT_OFF_FLAGS, 32'h7);
    pulse(3'h1, 5);
    snap(32'h5);
    rd(`FRT_OFF_FLAGS);
    chk("match flag kept", rd_val, 32'h1);
    $display("Test match no clear finished");

    wr(`FRT_OFF_PERIOD, 32'h1000);
    wr(`FRT_OFF_MODE, 32'h16);
    wr(`FRT_OFF_CTRL, 32'h5);
    wr(`FRT_OFF_FLAGS, 32'h7);
    pulse(3'h1, 255);
    rd(`FRT_OFF_FLAGS);
    chk("wide flags", rd_val, 32'h0);
    chk("narrow overflow", rd_sml, 32'h2);
    chk("narrow irq", irq_s, 1'b1);
    chk("wide irq", irq_o, 1'b0);
    snap(32'hff);
    pulse(3'h1, 1);
    snap(32'h100);
    chk("narrow wrap", rd_sml, 32'h0);
    $display("Test overflow finished");
    stop_test();
  end
endmodule : tb
